// >>> hdl/edc_params.svh
// timing and geometry constants for the edo dram controller
`ifndef EDC_PARAMS_SVH
`define EDC_PARAMS_SVH

`define EDC_CLK_NS        40
// dram timing figures in ns (fast speed grade)
`define EDC_T_RP_NS       30
`define EDC_T_RCD_NS      11
`define EDC_T_RAC_NS      50
`define EDC_T_AA_NS       25
`define EDC_T_CAC_NS      13
`define EDC_T_RAS_NS      50
`define EDC_T_CAS_NS      8
`define EDC_T_CSR_NS      5
`define EDC_T_CHR_NS      8
`define EDC_T_OD_NS       12
`define EDC_T_OEH_NS      8
`define EDC_T_RPS_NS      90
`define EDC_T_CLCH_NS     5
// refresh: 4096 cbr cycles per 64 ms, so one every 15625 ns
`define EDC_REF_PERIOD_NS 64000000
`define EDC_REF_CYCLES    4096
`define EDC_ROW_W         12
`define EDC_COL_W         10
`define EDC_DQ_W          16
`define EDC_CNT_W         16

`endif

// >>> hdl/edc_pkg.sv
// types for the edo dram controller
package edc_pkg;
	typedef enum logic [1:0]
	{
		EDC_OP_READ,
		EDC_OP_WRITE,
		EDC_OP_RMW
	} edc_op_t;

	typedef enum logic [3:0]
	{
		EDC_ST_IDLE,
		EDC_ST_PRE,
		EDC_ST_ROW,
		EDC_ST_COL,
		EDC_ST_WRLATE,
		EDC_ST_WRDATA,
		EDC_ST_CBR_SETUP,
		EDC_ST_CBR_ROW,
		EDC_ST_CBR_END
	} edc_state_t;

	// ceiling division of a time by the clock period, never below one cycle
	function automatic int unsigned edc_cycles(input int unsigned ns, input int unsigned clk_ns);
		int unsigned c;
		c = (ns + clk_ns - 1) / clk_ns;
		return (c == 0) ? 1 : c;
	endfunction : edc_cycles
endpackage : edc_pkg

// >>> hdl/edc_refresh_timer.sv
// refresh interval timer raising a request held until granted
`timescale 1ns/10ps
`include "edc_params.svh"
module edc_refresh_timer #(
	parameter int unsigned INTERVAL = 390
)(
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic grant_i,
	output logic      request_o
);
	logic [`EDC_CNT_W-1:0] cnt_reg;
	logic [`EDC_CNT_W-1:0] cnt_next;
	logic                  req_reg;
	logic                  req_next;

	initial
	begin
		if (INTERVAL < 2 || INTERVAL >= (1 << `EDC_CNT_W))
			$error("refresh interval out of range");
	end

	always_comb
	begin
		cnt_next = cnt_reg + `EDC_CNT_W'(1);
		req_next = req_reg;
		if (cnt_reg == `EDC_CNT_W'(INTERVAL - 1))
		begin
			cnt_next = '0;
			req_next = 1'b1;
		end
		else if (grant_i)
			req_next = 1'b0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= '0;
			req_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			req_reg <= req_next;
		end
	end

	assign request_o = req_reg;
endmodule : edc_refresh_timer

// >>> hdl/edc_ctrl.sv
// edo dram controller: request port to dram pins, with cbr refresh
`timescale 1ns/10ps
`include "edc_params.svh"
module edc_ctrl #(
	parameter int unsigned REF_INTERVAL =
		(`EDC_REF_PERIOD_NS / `EDC_REF_CYCLES) / `EDC_CLK_NS
)(
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	// user request port
	input  wire logic                   req_valid_i,
	input  wire edc_pkg::edc_op_t       req_op_i,
	input  wire logic [`EDC_ROW_W-1:0]  req_row_i,
	input  wire logic [`EDC_COL_W-1:0]  req_col_i,
	input  wire logic [1:0]             req_be_i,
	input  wire logic [`EDC_DQ_W-1:0]   req_wdata_i,
	output logic                        req_ready_o,
	output logic                        rsp_valid_o,
	output logic [`EDC_DQ_W-1:0]        rsp_rdata_o,
	// dram pins
	output logic                        row_strobe_n_o,
	output logic                        low_byte_col_strobe_n_o,
	output logic                        high_byte_col_strobe_n_o,
	output logic                        write_strobe_n_o,
	output logic                        out_enable_n_o,
	output logic [`EDC_ROW_W-1:0]       addr_o,
	input  wire logic [`EDC_DQ_W-1:0]   dq_i,
	output logic [`EDC_DQ_W-1:0]        dq_o,
	output logic [`EDC_DQ_W-1:0]        dq_oe_o
);
	// ==========================================================
	// cycle counts derived from the timing figures
	localparam int unsigned CLK = `EDC_CLK_NS;
	localparam int unsigned C_RP  = edc_pkg::edc_cycles(`EDC_T_RP_NS, CLK);
	localparam int unsigned C_RCD = edc_pkg::edc_cycles(`EDC_T_RCD_NS, CLK);
	localparam int unsigned C_RAS = edc_pkg::edc_cycles(`EDC_T_RAS_NS, CLK);
	// column phase must cover access from row, column address and column strobe
	localparam int unsigned C_ACC_A = edc_pkg::edc_cycles(`EDC_T_RAC_NS, CLK) - C_RCD;
	localparam int unsigned C_ACC_B = edc_pkg::edc_cycles(`EDC_T_AA_NS, CLK);
	localparam int unsigned C_ACC_C = edc_pkg::edc_cycles(`EDC_T_CAC_NS, CLK);
	localparam int unsigned C_ACC0 = (C_ACC_A > C_ACC_B) ? C_ACC_A : C_ACC_B;
	localparam int unsigned C_ACC = ((C_ACC0 > C_ACC_C) ? C_ACC0 : C_ACC_C) + 1;
	localparam int unsigned C_OD  = edc_pkg::edc_cycles(`EDC_T_OD_NS + `EDC_T_OEH_NS, CLK);
	localparam int unsigned C_CSR = edc_pkg::edc_cycles(`EDC_T_CSR_NS, CLK);
	localparam int unsigned C_CHR = edc_pkg::edc_cycles(`EDC_T_CHR_NS, CLK);
	localparam int unsigned C_CBR = (C_RAS > C_CHR) ? C_RAS : C_CHR;
	localparam int unsigned CW = 4;

	initial
	begin
		if (C_ACC >= (1 << CW) || C_CBR >= (1 << CW) || C_RP >= (1 << CW))
			$error("timing counts exceed counter width");
	end

	// ==========================================================
	// refresh request source
	logic ref_req;
	logic ref_grant;

	edc_refresh_timer #(
		.INTERVAL (REF_INTERVAL)
	) u_timer (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.grant_i   (ref_grant),
		.request_o (ref_req)
	);

	// ==========================================================
	// state machine
	edc_pkg::edc_state_t      st_reg, st_next;
	logic [CW-1:0]            cnt_reg, cnt_next;
	edc_pkg::edc_op_t         op_reg, op_next;
	logic [`EDC_COL_W-1:0]    col_reg, col_next;
	logic [1:0]               be_reg, be_next;
	logic [`EDC_DQ_W-1:0]     wd_reg, wd_next;
	logic [`EDC_DQ_W-1:0]     rd_reg, rd_next;
	logic                     rv_reg, rv_next;
	logic                     rdy_reg, rdy_next;
	logic                     ras_reg, ras_next;
	logic                     low_byte_col_strobe_n_reg, low_byte_col_strobe_n_next;
	logic                     high_byte_col_strobe_n_reg, high_byte_col_strobe_n_next;
	logic                     we_reg, we_next;
	logic                     oe_reg, oe_next;
	logic [`EDC_ROW_W-1:0]    ad_reg, ad_next;
	logic                     drv_reg, drv_next;

	always_comb
	begin
		st_next   = st_reg;
		cnt_next  = cnt_reg - CW'(1);
		op_next   = op_reg;
		col_next  = col_reg;
		be_next   = be_reg;
		wd_next   = wd_reg;
		rd_next   = rd_reg;
		rv_next   = 1'b0;
		rdy_next  = 1'b0;
		ras_next  = ras_reg;
		low_byte_col_strobe_n_next = low_byte_col_strobe_n_reg;
		high_byte_col_strobe_n_next = high_byte_col_strobe_n_reg;
		we_next   = we_reg;
		oe_next   = oe_reg;
		ad_next   = ad_reg;
		drv_next  = drv_reg;
		ref_grant = 1'b0;
		case (st_reg)
			edc_pkg::EDC_ST_IDLE:
			begin
				// a raised ready is a promise, so a seen request beats a new refresh
				if (req_valid_i && rdy_reg)
				begin
					op_next  = req_op_i;
					col_next = req_col_i;
					be_next  = (req_be_i == 2'b00) ? 2'b11 : req_be_i;
					wd_next  = req_wdata_i;
					ad_next  = req_row_i;
					ras_next = 1'b0;
					// early write: write strobe low before column strobe
					we_next  = (req_op_i != edc_pkg::EDC_OP_WRITE);
					oe_next  = (req_op_i == edc_pkg::EDC_OP_WRITE);
					drv_next = (req_op_i == edc_pkg::EDC_OP_WRITE);
					cnt_next = CW'(C_RCD);
					st_next  = edc_pkg::EDC_ST_ROW;
				end
				else if (ref_req)
				begin
					// column strobes are high here, so a row fall starts a fresh cycle
					ref_grant = 1'b1; // cbr only
					low_byte_col_strobe_n_next = 1'b0;
					high_byte_col_strobe_n_next = 1'b0;
					we_next   = 1'b1;
					cnt_next  = CW'(C_CSR);
					st_next   = edc_pkg::EDC_ST_CBR_SETUP;
				end
				else
					rdy_next = 1'b1;
			end
			edc_pkg::EDC_ST_ROW:
			begin
				if (cnt_reg == CW'(1))
				begin
					ad_next   = `EDC_ROW_W'(col_reg);
					// each byte strobe falls only if its enable bit is set; both rise together
					low_byte_col_strobe_n_next = ~be_reg[0];
					high_byte_col_strobe_n_next = ~be_reg[1];
					cnt_next  = CW'(C_ACC);
					st_next   = edc_pkg::EDC_ST_COL;
				end
			end
			edc_pkg::EDC_ST_COL:
			begin
				if (cnt_reg == CW'(1))
				begin
					if (op_reg == edc_pkg::EDC_OP_READ)
					begin
						rd_next = dq_i;
						rv_next = 1'b1;
						st_next = edc_pkg::EDC_ST_PRE;
						// write strobe stays high until both strobes are back up
						ras_next  = 1'b1;
						low_byte_col_strobe_n_next = 1'b1;
						high_byte_col_strobe_n_next = 1'b1;
						oe_next   = 1'b1;
						cnt_next  = CW'(C_RP);
					end
					else if (op_reg == edc_pkg::EDC_OP_RMW)
					begin
						rd_next  = dq_i;
						rv_next  = 1'b1;
						oe_next  = 1'b1;
						cnt_next = CW'(C_OD);
						st_next  = edc_pkg::EDC_ST_WRLATE;
					end
					else
					begin
						ras_next  = 1'b1;
						low_byte_col_strobe_n_next = 1'b1;
						high_byte_col_strobe_n_next = 1'b1;
						we_next   = 1'b1;
						drv_next  = 1'b0; // row closes after every access, no page cycles
						cnt_next  = CW'(C_RP);
						st_next   = edc_pkg::EDC_ST_PRE;
					end
				end
			end
			edc_pkg::EDC_ST_WRLATE:
			begin
				// outputs are off before we drive
				if (cnt_reg == CW'(1))
				begin
					we_next  = 1'b0;
					drv_next = 1'b1;
					cnt_next = CW'(C_CHR);
					st_next  = edc_pkg::EDC_ST_WRDATA;
				end
			end
			edc_pkg::EDC_ST_WRDATA:
			begin
				if (cnt_reg == CW'(1))
				begin
					ras_next  = 1'b1;
					low_byte_col_strobe_n_next = 1'b1;
					high_byte_col_strobe_n_next = 1'b1;
					we_next   = 1'b1;
					drv_next  = 1'b0;
					cnt_next  = CW'(C_RP);
					st_next   = edc_pkg::EDC_ST_PRE;
				end
			end
			edc_pkg::EDC_ST_CBR_SETUP:
			begin
				if (cnt_reg == CW'(1))
				begin
					ras_next = 1'b0;
					cnt_next = CW'(C_CBR);
					st_next  = edc_pkg::EDC_ST_CBR_ROW;
				end
			end
			edc_pkg::EDC_ST_CBR_ROW:
			begin
				// row low time of 80 ns stays under the 90 ns self-refresh entry pulse, so no entry
				if (cnt_reg == CW'(1))
				begin
					ras_next  = 1'b1;
					low_byte_col_strobe_n_next = 1'b1;
					high_byte_col_strobe_n_next = 1'b1;
					cnt_next  = CW'(C_RP);
					st_next   = edc_pkg::EDC_ST_PRE;
				end
			end
			edc_pkg::EDC_ST_PRE:
			begin
				if (cnt_reg == CW'(1))
				begin
					oe_next  = 1'b1;
					st_next  = edc_pkg::EDC_ST_IDLE;
					rdy_next = ~ref_req;
				end
			end
			default:
			begin
				st_next = edc_pkg::EDC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			st_reg   <= edc_pkg::EDC_ST_PRE;
			cnt_reg  <= CW'(C_RP);
			op_reg   <= edc_pkg::EDC_OP_READ;
			col_reg  <= '0;
			be_reg   <= 2'b11;
			wd_reg   <= '0;
			rd_reg   <= '0;
			rv_reg   <= 1'b0;
			rdy_reg  <= 1'b0;
			ras_reg  <= 1'b1;
			low_byte_col_strobe_n_reg <= 1'b1;
			high_byte_col_strobe_n_reg <= 1'b1;
			we_reg   <= 1'b1;
			oe_reg   <= 1'b1;
			ad_reg   <= '0;
			drv_reg  <= 1'b0;
		end
		else
		begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			op_reg   <= op_next;
			col_reg  <= col_next;
			be_reg   <= be_next;
			wd_reg   <= wd_next;
			rd_reg   <= rd_next;
			rv_reg   <= rv_next;
			rdy_reg  <= rdy_next;
			ras_reg  <= ras_next;
			low_byte_col_strobe_n_reg <= low_byte_col_strobe_n_next;
			high_byte_col_strobe_n_reg <= high_byte_col_strobe_n_next;
			we_reg   <= we_next;
			oe_reg   <= oe_next;
			ad_reg   <= ad_next;
			drv_reg  <= drv_next;
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops
	assign req_ready_o              = rdy_reg;
	assign rsp_valid_o              = rv_reg;
	assign rsp_rdata_o              = rd_reg;
	assign row_strobe_n_o           = ras_reg;
	assign low_byte_col_strobe_n_o  = low_byte_col_strobe_n_reg;
	assign high_byte_col_strobe_n_o = high_byte_col_strobe_n_reg;
	assign write_strobe_n_o         = we_reg;
	assign out_enable_n_o           = oe_reg;
	assign addr_o                   = ad_reg;
	assign dq_o                     = wd_reg;
	// drive whole word; the device latches only lanes whose strobe is low
	assign dq_oe_o                  = {`EDC_DQ_W{drv_reg}};
endmodule : edc_ctrl

// >>> tb/edc_ctrl_sva.sv
// assertions on the edo dram controller pins
`timescale 1ns/10ps
module edc_ctrl_sva #(
	parameter int unsigned REF_INTERVAL = 390
)(
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic        req_valid_i,
	input wire logic        req_ready_o,
	input wire logic        rsp_valid_o,
	input wire logic        row_strobe_n_o,
	input wire logic        low_byte_col_strobe_n_o,
	input wire logic        high_byte_col_strobe_n_o,
	input wire logic        write_strobe_n_o,
	input wire logic        out_enable_n_o,
	input wire logic [15:0] dq_oe_o
);
	// ==========================================
	// helper: cycles since the last refresh
	wire         col_lo = !low_byte_col_strobe_n_o || !high_byte_col_strobe_n_o;
	logic        row_reg, row_next;
	int unsigned gap_reg, gap_next;
	always_comb
	begin
		row_next = row_strobe_n_o;
		gap_next = (row_reg && !row_strobe_n_o && col_lo) ? '0 : gap_reg + 1;
	end
	always_ff @(posedge clk_sys_i)
	begin
		row_reg <= rst_n_i ? row_next : 1'b1;
		gap_reg <= rst_n_i ? gap_next : '0;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// assertions
	a_cbr_setup: assert property ($fell(row_strobe_n_o) && col_lo |-> $past(col_lo))
		else $error("column strobe not set up before refresh");
	a_cbr_hold: assert property ($fell(row_strobe_n_o) && col_lo |=> col_lo && !row_strobe_n_o)
		else $error("refresh strobes not held");
	a_early_write: assert property ($rose(col_lo) && !write_strobe_n_o |-> !$past(write_strobe_n_o))
		else $error("write strobe fell with column strobe");
	a_late_oe_high: assert property ($fell(write_strobe_n_o) && col_lo |-> out_enable_n_o && $past(out_enable_n_o))
		else $error("late write without output disable");
	a_drive_we: assert property (|dq_oe_o |-> !write_strobe_n_o && out_enable_n_o)
		else $error("data driven outside a write");
	a_read_hold: assert property ($rose(row_strobe_n_o) && !$past(out_enable_n_o) |-> $past(write_strobe_n_o))
		else $error("read command not held");
	a_sample_wait: assert property ($rose(rsp_valid_o) |-> !$past(row_strobe_n_o, 3) && !$past(row_strobe_n_o) && $past(col_lo, 2) && $past(col_lo))
		else $error("read data taken before access time");
	a_refresh_gap: assert property (gap_reg <= REF_INTERVAL + 16)
		else $error("refresh interval overrun");
	a_ready_drop: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
		else $error("ready stayed high after accept");
	c_read: cover property ($rose(rsp_valid_o));
	c_refresh: cover property ($fell(row_strobe_n_o) && col_lo);
	c_late_write: cover property ($fell(write_strobe_n_o) && col_lo);
endmodule : edc_ctrl_sva

// >>> tb/edc_dram_model.sv
// behavioural edo dram model facing the controller
`timescale 1ns/10ps
module edc_dram_model (
	input  wire logic        row_strobe_n_i,
	input  wire logic        low_byte_col_strobe_n_i,
	input  wire logic        high_byte_col_strobe_n_i,
	input  wire logic        write_strobe_n_i,
	input  wire logic        out_enable_n_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic      [15:0] dq_o,
	output int unsigned      refresh_count_o
);
	// ==========================================
	// array and cycle state, small aliased array
	logic [15:0] mem [0:255];
	logic [3:0]  row_q, col_q;
	logic        column_before_row_refresh, wrote;
	wire         lo = !low_byte_col_strobe_n_i;
	wire         hi = !high_byte_col_strobe_n_i;
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h0000;
		row_q = 4'h0;
		col_q = 4'h0;
		column_before_row_refresh = 1'b0;
		wrote = 1'b0;
		refresh_count_o = 0;
	end
	task automatic store();
		if (lo) mem[{row_q, col_q}][7:0] = dq_i[7:0];
		if (hi) mem[{row_q, col_q}][15:8] = dq_i[15:8];
		wrote = 1'b1;
	endtask : store
	// ==========================================
	// edges; #1 lets same-edge address and data land
	always @(negedge row_strobe_n_i)
	begin
		#1;
		column_before_row_refresh = lo || hi;
		if (column_before_row_refresh) refresh_count_o++;
		else row_q = addr_i[3:0];
	end
	always @(negedge low_byte_col_strobe_n_i or negedge high_byte_col_strobe_n_i)
	begin
		#1;
		if (!column_before_row_refresh) col_q = addr_i[3:0];
		if (!column_before_row_refresh && !write_strobe_n_i) store();
	end
	always @(negedge write_strobe_n_i)
	begin
		#1;
		if (!row_strobe_n_i && !column_before_row_refresh && (lo || hi)) store();
	end
	always @(posedge low_byte_col_strobe_n_i or posedge high_byte_col_strobe_n_i)
		// read the pins, not the derived wires, which may not have settled yet
		if (low_byte_col_strobe_n_i && high_byte_col_strobe_n_i) wrote = 1'b0;
	// floating lanes show the inverse so early sampling is caught
	wire [15:0] on = {{8{hi}}, {8{lo}}} & {16{!out_enable_n_i && write_strobe_n_i && !wrote && !column_before_row_refresh}};
	assign dq_o = mem[{row_q, col_q}] ^ ~on;
endmodule : edc_dram_model

// >>> tb/test_edc_ctrl.sv
// self-checking bench for the edo dram controller
`timescale 1ns/10ps
`include "edc_params.svh"
module test_edc_ctrl;
	localparam int unsigned REF_INTERVAL = 20;
	logic             clk_sys_i, rst_n_i, req_valid_i, req_ready_o, rsp_valid_o;
	logic             row_strobe_n_o, low_byte_col_strobe_n_o, high_byte_col_strobe_n_o;
	logic             write_strobe_n_o, out_enable_n_o;
	edc_pkg::edc_op_t req_op_i;
	logic [11:0]      req_row_i, addr_o;
	logic [9:0]       req_col_i;
	logic [1:0]       req_be_i;
	logic [15:0]      req_wdata_i, rsp_rdata_o, dq_i, dq_o, dq_oe_o, got;
	int unsigned      fail_count, samples_checked, cycles, refs, ref0;
	edc_ctrl #(.REF_INTERVAL(REF_INTERVAL)) dut (.clk_sys_i, .rst_n_i, .req_valid_i,
		.req_op_i, .req_row_i, .req_col_i, .req_be_i, .req_wdata_i, .req_ready_o,
		.rsp_valid_o, .rsp_rdata_o, .row_strobe_n_o, .low_byte_col_strobe_n_o,
		.high_byte_col_strobe_n_o, .write_strobe_n_o, .out_enable_n_o, .addr_o,
		.dq_i, .dq_o, .dq_oe_o);
	edc_dram_model u_mem (.row_strobe_n_i(row_strobe_n_o),
		.low_byte_col_strobe_n_i(low_byte_col_strobe_n_o),
		.high_byte_col_strobe_n_i(high_byte_col_strobe_n_o),
		.write_strobe_n_i(write_strobe_n_o), .out_enable_n_i(out_enable_n_o),
		.addr_i(addr_o), .dq_i(dq_o), .dq_o(dq_i), .refresh_count_o(refs));
	// ==========================================
	// common tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	// request held until a rising edge sees ready high
	task automatic op(input edc_pkg::edc_op_t o, input logic [11:0] r,
		input logic [9:0] c, input logic [1:0] be, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		req_valid_i = 1'b1;
		req_op_i = o;
		req_row_i = r;
		req_col_i = c;
		req_be_i = be;
		req_wdata_i = d;
		// ready seen at a falling edge means the next rising edge takes the request
		while (req_ready_o !== 1'b1 && n < 60)
		begin
			n++;
			@(negedge clk_sys_i);
		end
		@(negedge clk_sys_i);
		req_valid_i = 1'b0;
		if (n >= 60)
			fail_count++;
		if (o == edc_pkg::EDC_OP_WRITE) return;
		while (rsp_valid_o !== 1'b1 && n < 90)
		begin
			n++;
			@(negedge clk_sys_i);
		end
		if (n >= 90)
			fail_count++;
		got = (n < 90) ? rsp_rdata_o : ~got;
	endtask : op
	// ==========================================
	// scenarios
	task automatic t_write_read();
		for (int i = 1; i < 5; i++)
			op(edc_pkg::EDC_OP_WRITE, 12'(i), 10'(5 - i), 2'h3, 16'ha5c3 ^ 16'(i));
		for (int i = 1; i < 5; i++)
		begin
			op(edc_pkg::EDC_OP_READ, 12'(i), 10'(5 - i), 2'h3, 16'h0000);
			chk(got, 16'ha5c3 ^ 16'(i));
		end
	endtask : t_write_read
	task automatic t_bytes();
		logic [15:0] wd [4];
		logic [1:0]  be [4];
		logic [15:0] ex [4];
		wd = '{16'h1234, 16'hffaa, 16'h56ff, 16'h9876};
		be = '{2'h3, 2'h1, 2'h2, 2'h0};
		ex = '{16'h1234, 16'h12aa, 16'h56aa, 16'h9876};
		for (int i = 0; i < 4; i++)
		begin
			op(edc_pkg::EDC_OP_WRITE, 12'h007, 10'h009, be[i], wd[i]);
			op(edc_pkg::EDC_OP_READ, 12'h007, 10'h009, 2'h3, 16'h0000);
			chk(got, ex[i]);
		end
	endtask : t_bytes
	task automatic t_rmw();
		op(edc_pkg::EDC_OP_WRITE, 12'h00c, 10'h003, 2'h3, 16'hbeef);
		op(edc_pkg::EDC_OP_RMW, 12'h00c, 10'h003, 2'h3, 16'h0f0f);
		chk(got, 16'hbeef);
		op(edc_pkg::EDC_OP_RMW, 12'h00c, 10'h003, 2'h1, 16'h00aa);
		// only the low lane strobe falls, so the high lane floats
		chk({8'h00, got[7:0]}, 16'h000f);
		op(edc_pkg::EDC_OP_READ, 12'h00c, 10'h003, 2'h3, 16'h0000);
		chk(got, 16'h0faa);
	endtask : t_rmw
	task automatic t_refresh();
		ref0 = refs;
		repeat (5 * REF_INTERVAL) @(negedge clk_sys_i);
		chk({15'h0000, (refs - ref0) >= 4}, 16'h0001);
	endtask : t_refresh
	// ==========================================
	// clock, timeout and main sequence
	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			results();
		end
	end
	initial
	begin
		{rst_n_i, req_valid_i, req_row_i, req_col_i, req_be_i, req_wdata_i} = '0;
		req_op_i = edc_pkg::EDC_OP_READ;
		{fail_count, samples_checked, cycles} = '0;
		got = 16'h0000;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk({11'h000, row_strobe_n_o, low_byte_col_strobe_n_o, high_byte_col_strobe_n_o,
			write_strobe_n_o, req_ready_o}, 16'h001e);
		chk(dq_oe_o, 16'h0000);
		rst_n_i = 1'b1;
		t_write_read();
		t_bytes();
		t_rmw();
		t_refresh();
		results();
	end
endmodule : test_edc_ctrl
bind edc_ctrl edc_ctrl_sva #(.REF_INTERVAL(REF_INTERVAL)) u_sva (.clk_sys_i, .rst_n_i,
	.req_valid_i, .req_ready_o, .rsp_valid_o, .row_strobe_n_o, .low_byte_col_strobe_n_o,
	.high_byte_col_strobe_n_o, .write_strobe_n_o, .out_enable_n_o, .dq_oe_o);
